// ### aos_serializer.sv
// output data path of a dual-channel converter: conversion timing, busy,
// result hold and the lane serializer that runs on the link bit clock
// assumes the converter core presents its (possibly averaged) words on
// core_words and that link_clk is the host serial clock, or the internal
// oscillator when the oscillator source is selected
//
// Function
// [RL1] code 0x2 splits each word over four lanes
// [RL2] four lanes need a quarter of pulses
// [RL3] code 0x3 selects interleaved layout
// [RL4] interleaved puts both channels on lane 0
// [RL5] interleaved needs twice the single-lane pulses
// [RL6] interleaved read in zone 1 or 2
// [RL7] lane map: 0/4, 0-1/4-5, 0-3/4-7
// [RL8] host clock source allows single rate only
// [RL9] echo and oscillator allow both rates
// [RL10] words 24/32, interleaved 48/64 bits
// [RL11] echo/oscillator: busy pin carries bit clock
// [RL12] start 10/20 ns; convert in 264-300 ns
// [RL13] host allows bits over lanes-rate-factor time
// [RL14] zone 1 period covers transfer, conversion, quiet
// [RL15] zone 2 period covers transfer and quiets
// [RL16] averaging busy spans all averaged periods
// [RL17] averaged result readable when busy falls
// [RL18] host times chip select without busy
// [RL19] host reassembles words from several lanes
// [RL20] host splits interleaved lane 0 stream
// [RL21] host quiet 19.6 ns before, 9.8 after
// [RL22] host waits 300 ns before chip select
// [RL23] source codes: host 0, echo 1, oscillator 2
// [RL24] double rate shifts on both edges
// [RL25] lanes times pulses equals word length
// [RL26] host configures only between transfers
`include "aos_params.svh"
`timescale 1ns/1ps
`default_nettype none

module aos_serializer #(
  parameter int AVG_W = 5
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  wire logic                conversion_start,
  input  wire logic                cs_n,
  input  wire logic                link_clk,
  input  wire aos_pkg::aos_cfg_t   cfg,
  input  wire logic                avg_enable,
  input  wire logic [AVG_W-1:0]    avg_log2,
  input  wire aos_pkg::aos_words_t core_words,
  output logic                     busy_or_returned_clock,
  output logic                     serial_out_lane_0,
  output logic                     serial_out_lane_1,
  output logic                     serial_out_lane_2,
  output logic                     serial_out_lane_3,
  output logic                     serial_out_lane_4,
  output logic                     serial_out_lane_5,
  output logic                     serial_out_lane_6,
  output logic                     serial_out_lane_7
);
  import aos_pkg::*;

  localparam int CONV_DLY = `AOS_CONV_CYCLES;
  localparam logic [6:0] CONV_CYC = 7'(`AOS_CONV_CYCLES);

  // word length per channel
  function automatic int word_len(input aos_cfg_t c);
    word_len = c.word_32_select ? `AOS_WORD_LONG : `AOS_WORD_SHORT; // RL10
  endfunction

  // lanes per channel: 1, 2 or 4; interleaved counts as one
  function automatic int lane_cnt(input aos_cfg_t c);
    unique case (c.lane_layout_field)
      `AOS_LAYOUT_TWO:  lane_cnt = 2;
      `AOS_LAYOUT_FOUR: lane_cnt = 4; // RL1
      default:          lane_cnt = 1;
    endcase
  endfunction

  // double rate only where the device makes or echoes the clock
  function automatic logic ddr_eff(input aos_cfg_t c);
    ddr_eff = c.double_rate_select && (c.bit_clock_source_field != `AOS_SRC_HOST); // RL8 RL9
  endfunction

  // bit clock pulses needed for one result
  function automatic logic [6:0] pulse_limit(input aos_cfg_t c);
    int bits;
    bits = (c.lane_layout_field == `AOS_LAYOUT_ILV) ? 2 * word_len(c) // RL5
                                                    : word_len(c) / lane_cnt(c); // RL2 RL25
    if (ddr_eff(c)) begin
      bits = bits / 2; // RL24
    end
    pulse_limit = 7'(bits);
  endfunction

  // lane values for one bit slot, msb first
  function automatic logic [7:0] lane_bits(input aos_words_t w, input aos_cfg_t c, input logic [7:0] slot);
    int wl;
    int m;
    int pos;
    logic [7:0] r;
    wl = word_len(c);
    m  = lane_cnt(c);
    r  = 8'h00;
    if (c.lane_layout_field == `AOS_LAYOUT_ILV) begin
      // ch0 then ch1 bit of equal weight, lane 0 only
      if (int'(slot) < 2 * wl) begin // RL4
        pos  = wl - 1 - int'(slot) / 2;
        r[0] = slot[0] ? w.ch1[pos] : w.ch0[pos];
      end
    end else begin
      for (int j = 0; j < 4; j++) begin
        pos = int'(slot) * m + j;
        if (j < m && pos < wl) begin // RL7
          r[j]     = w.ch0[wl - 1 - pos];
          r[4 + j] = w.ch1[wl - 1 - pos];
        end
      end
    end
    lane_bits = r;
  endfunction

  // ---------------- reference clock domain ----------------
  logic       start_sync;
  logic       cs_n_sync;
  logic       start_dly_reg;
  logic       start_pulse;
  logic [6:0] conv_cnt_reg;
  logic       conv_done;
  logic       busy_reg;
  logic [15:0] smp_cnt_reg;
  logic       avg_last;
  logic       pend_reg;
  aos_words_t result_reg;

  aos_sync2 #(.WIDTH(1), .INIT(1'b0)) u_start_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .async_in (conversion_start),
    .sync_out (start_sync)
  );

  aos_sync2 #(.WIDTH(1), .INIT(1'b1)) u_cs_sync (
    .clk      (ref_clk),
    .rst_n    (rst_n),
    .async_in (cs_n),
    .sync_out (cs_n_sync)
  );

  // rising edge of the synchronised start pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_dly_reg <= 1'b0;
    end else begin
      start_dly_reg <= start_sync;
    end
  end
  assign start_pulse = start_sync && !start_dly_reg;

  // conversion timer; a start during a running conversion is ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_cnt_reg <= 7'h00;
    end else if (start_pulse && conv_cnt_reg == 7'h00) begin
      conv_cnt_reg <= CONV_CYC; // RL12
    end else if (conv_cnt_reg != 7'h00) begin
      conv_cnt_reg <= conv_cnt_reg - 7'h01;
    end
  end
  assign conv_done = (conv_cnt_reg == 7'h01);

  // averaged sample counter, block size 2**avg_log2 for avg_log2 up to 16, else 2**16
  assign avg_last = !avg_enable || (smp_cnt_reg == 16'((32'h1 << avg_log2) - 32'h1));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt_reg <= 16'h0000;
    end else if (conv_done) begin
      smp_cnt_reg <= avg_last ? 16'h0000 : smp_cnt_reg + 16'h0001;
    end
  end

  // busy spans every conversion of an averaging block
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'b0;
    end else if (conv_done && avg_last) begin
      busy_reg <= 1'b0; // RL16
    end else if (start_pulse) begin
      busy_reg <= 1'b1;
    end
  end

  // result is frozen while a frame runs so the link side loads a stable word;
  // a result finished mid-frame is taken over once chip select rises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= '0;
      pend_reg   <= 1'b0;
    end else if (conv_done && avg_last && cs_n_sync) begin
      result_reg <= core_words; // RL17
      pend_reg   <= 1'b0;
    end else if (conv_done && avg_last) begin
      pend_reg   <= 1'b1; // RL6
    end else if (pend_reg && cs_n_sync) begin
      result_reg <= core_words;
      pend_reg   <= 1'b0;
    end
  end

  // ---------------- link clock domain ----------------
  // frame state is cleared by chip select itself, since the link clock
  // may stand still between frames
  logic       lk_arst_n;
  logic       started_reg;
  logic [6:0] step_reg;
  logic [6:0] lim_reg;
  aos_cfg_t   cfg_l_reg;
  aos_words_t words_l_reg;
  logic [7:0] lanes_pos_reg;
  logic [7:0] lanes_neg_reg;
  logic       gate_reg;
  logic       spent_reg;
  aos_cfg_t   cur_cfg;
  logic [6:0] cur_lim;
  logic       cur_ddr;
  logic [7:0] lanes_out;
  logic       ret_clk;

  assign lk_arst_n = rst_n && !cs_n;
  assign cur_cfg   = started_reg ? cfg_l_reg : cfg;
  assign cur_lim   = started_reg ? lim_reg : pulse_limit(cfg);
  assign cur_ddr   = ddr_eff(cur_cfg);

  // frame capture and rising-edge shifting
  always_ff @(posedge link_clk or negedge lk_arst_n) begin
    if (!lk_arst_n) begin
      started_reg   <= 1'b0;
      step_reg      <= 7'h00;
      lim_reg       <= 7'h00;
      cfg_l_reg     <= '0;
      words_l_reg   <= '0;
      lanes_pos_reg <= 8'h00;
      spent_reg     <= 1'b0;
    end else if (!started_reg) begin
      started_reg   <= 1'b1;
      cfg_l_reg     <= cfg; // RL3
      words_l_reg   <= result_reg;
      lim_reg       <= pulse_limit(cfg); // RL25
      step_reg      <= 7'h01;
      lanes_pos_reg <= lane_bits(result_reg, cfg, 8'h00);
    end else if (step_reg < lim_reg) begin
      step_reg      <= step_reg + 7'h01;
      lanes_pos_reg <= lane_bits(words_l_reg, cfg_l_reg,
                                 cur_ddr ? {step_reg, 1'b0} : {1'b0, step_reg}); // RL24
    end else begin
      lanes_pos_reg <= 8'h00;
      spent_reg     <= 1'b1; // step stalls at the limit, so mark the frame as used up
    end
  end

  // falling-edge half of double rate: odd slot of the step just shown;
  // quiet once the limit is passed, else the last odd slot would repeat
  always_ff @(negedge link_clk or negedge lk_arst_n) begin
    if (!lk_arst_n) begin
      lanes_neg_reg <= 8'h00;
    end else if (started_reg && cur_ddr && step_reg <= lim_reg && step_reg != 7'h00 && !spent_reg) begin
      lanes_neg_reg <= lane_bits(words_l_reg, cfg_l_reg, {step_reg, 1'b0} - 8'h01); // RL24
    end else begin
      lanes_neg_reg <= 8'h00;
    end
  end

  // returned clock gate, changed on the low phase to avoid glitches;
  // the oscillator source stops after the computed pulse count
  always_ff @(negedge link_clk or negedge lk_arst_n) begin
    if (!lk_arst_n) begin
      gate_reg <= 1'b0;
    end else if (cur_cfg.bit_clock_source_field == `AOS_SRC_OSC) begin
      gate_reg <= (step_reg < cur_lim); // RL23
    end else begin
      gate_reg <= 1'b1;
    end
  end

  // lane outputs and the shared busy/clock pin
  assign lanes_out = (cur_ddr && !link_clk) ? lanes_neg_reg : lanes_pos_reg;
  assign ret_clk   = link_clk && gate_reg;
  assign busy_or_returned_clock = (cfg.bit_clock_source_field == `AOS_SRC_HOST) ? busy_reg : ret_clk; // RL11
  assign serial_out_lane_0 = lanes_out[0];
  assign serial_out_lane_1 = lanes_out[1];
  assign serial_out_lane_2 = lanes_out[2];
  assign serial_out_lane_3 = lanes_out[3];
  assign serial_out_lane_4 = lanes_out[4];
  assign serial_out_lane_5 = lanes_out[5];
  assign serial_out_lane_6 = lanes_out[6];
  assign serial_out_lane_7 = lanes_out[7];

  // ---------------- checks ----------------
  a_conv_done_time: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL12
    (start_pulse && conv_cnt_reg == 7'h00) |-> ##CONV_DLY conv_done)
    else $error("conversion did not end at the fixed delay");

  a_busy_fall_cause: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL16
    $fell(busy_reg) |-> $past(conv_done && avg_last))
    else $error("busy fell before the last averaged sample");

  a_result_at_fall: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL17
    ($fell(busy_reg) && $past(cs_n_sync)) |-> (result_reg == $past(core_words)))
    else $error("result not present when busy fell");

  a_quad_pulses: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL2
    (!started_reg && cfg.lane_layout_field == `AOS_LAYOUT_FOUR && !ddr_eff(cfg))
      |=> (lim_reg == 7'(word_len(cfg_l_reg) / 4)))
    else $error("four-lane pulse count wrong");

  a_ilv_pulses: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL5
    (!started_reg && cfg.lane_layout_field == `AOS_LAYOUT_ILV && !ddr_eff(cfg))
      |=> (lim_reg == 7'(2 * word_len(cfg_l_reg))))
    else $error("interleaved pulse count wrong");

  a_ilv_lane_zero: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL4
    (started_reg && cfg_l_reg.lane_layout_field == `AOS_LAYOUT_ILV) |=> (lanes_pos_reg[7:1] == 7'h00))
    else $error("interleaved data outside lane 0");

  a_single_lane_map: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL7
    (started_reg && cfg_l_reg.lane_layout_field == `AOS_LAYOUT_ONE)
      |=> (lanes_pos_reg[3:1] == 3'h0 && lanes_pos_reg[7:5] == 3'h0))
    else $error("single-lane data on an idle lane");

  a_ddr_tail_quiet: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL25
    (started_reg && spent_reg) |-> (lanes_neg_reg == 8'h00))
    else $error("falling-edge data after the pulse limit");

  a_host_sdr_only: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL8
    (started_reg && cfg_l_reg.bit_clock_source_field == `AOS_SRC_HOST) |-> (lanes_neg_reg == 8'h00))
    else $error("double rate used with host clock");

  a_total_bits: assert property (@(posedge link_clk) disable iff (!lk_arst_n) // RL25
    (started_reg && cfg_l_reg.lane_layout_field != `AOS_LAYOUT_ILV)
      |-> (int'(lim_reg) * lane_cnt(cfg_l_reg) * (ddr_eff(cfg_l_reg) ? 2 : 1) == word_len(cfg_l_reg)))
    else $error("lanes times pulses differs from word length");

  a_busy_pin_src: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL11
    (cfg.bit_clock_source_field != `AOS_SRC_HOST && cs_n_sync && $stable(cs_n_sync))
      |-> !busy_or_returned_clock || !cs_n)
    else $error("busy shown while the pin carries the bit clock");

endmodule

`default_nettype wire

// ### aos_params.svh
// constants of the multilane output serializer: field codes, word lengths and timing
// assumes a 250 MHz reference clock; included by the serializer module only
`ifndef AOS_PARAMS_SVH
`define AOS_PARAMS_SVH

// lane layout field codes
`define AOS_LAYOUT_ONE   2'h0
`define AOS_LAYOUT_TWO   2'h1
`define AOS_LAYOUT_FOUR  2'h2
`define AOS_LAYOUT_ILV   2'h3

// bit clock source field codes
`define AOS_SRC_HOST     2'h0
`define AOS_SRC_ECHO     2'h1
`define AOS_SRC_OSC      2'h2

// word lengths per channel
`define AOS_WORD_SHORT   24
`define AOS_WORD_LONG    32

// conversion timing, in ns as printed, reference period and quiet times in ps
`define AOS_REF_PERIOD_PS     4000
`define AOS_CONV_MIN_NS       264
`define AOS_CONV_MAX_NS       300
`define AOS_CONV_TYP_NS       282
`define AOS_START_HIGH_MIN_NS 10
`define AOS_START_LOW_MIN_NS  20
`define AOS_PRE_QUIET_PS      19600
`define AOS_POST_QUIET_PS     9800

// cycles from the detected start edge to the end of conversion; the typical
// figure rounded down, plus three cycles of pin sync and edge detection, lands
// inside the 264..300 ns window
`define AOS_CONV_CYCLES ((`AOS_CONV_TYP_NS * 1000) / `AOS_REF_PERIOD_PS)
`define AOS_SYNC_LAT_CYCLES 3

`endif

// ### aos_pkg.sv
// types shared by the multilane output serializer
// assumes aos_params.svh for the field codes
package aos_pkg;

  // output configuration, static while a transfer runs
  typedef struct packed {
    logic [1:0] lane_layout_field;
    logic [1:0] bit_clock_source_field;
    logic       double_rate_select;
    logic       word_32_select;
  } aos_cfg_t;

  // one conversion result, both channels
  typedef struct packed {
    logic [31:0] ch1;
    logic [31:0] ch0;
  } aos_words_t;

endpackage

// ### aos_sync2.sv
// two flip-flop synchroniser for levels arriving from another clock domain
// assumes the destination clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module aos_sync2 #(
  parameter int    WIDTH = 1,
  parameter logic  INIT  = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{INIT}};
      sync_out <= {WIDTH{INIT}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// ### aos_host_model.sv
// host controller model: start pulses, chip select, bit clock and lane capture
// assumes a 250 MHz ref_clk; its own 6 ns bit clock runs only inside frames
`timescale 1ns/1ps
`default_nettype none

module aos_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] lanes,
  input  wire logic       ret_clk,
  output logic            conversion_start,
  output logic            cs_n,
  output logic            link_clk
);
  logic [31:0] got0;
  logic [31:0] got1;
  logic        tail_zero;
  logic        ret_hi;
  logic        ret_lo;

  // idle: no frame, bit clock parked low
  initial begin
    conversion_start = 1'b0;
    cs_n             = 1'b1;
    link_clk         = 1'b0;
  end

  // start held three cycles (12 ns) high; callers keep it low long enough
  task automatic start_conv();
    @(posedge ref_clk) conversion_start <= 1'b1;
    repeat (3) @(posedge ref_clk);
    conversion_start <= 1'b0;
  endtask

  // one slot of each lane in use (lane 0 only when interleaved); past the pulse limit all lanes must read zero
  task automatic take(int s, int nl, bit ilv, int w, bit tail);
    if (tail) tail_zero &= (lanes === 8'h00);
    else if (ilv) begin
      if (s % 2 == 0) got0[w-1-s/2] = lanes[0];
      else got1[w-1-s/2] = lanes[0];
    end else
      for (int j = 0; j < nl; j++) begin
        got0[w-1-(s*nl+j)] = lanes[j];
        got1[w-1-(s*nl+j)] = lanes[4+j];
      end
  endtask

  // frame of pulses plus one spare; lanes sampled late in each high half, and late in each low half at double rate
  task automatic read(int nl, bit ilv, bit ddr, int w, int pulses);
    got0      = '0;
    got1      = '0;
    tail_zero = 1'b1;
    @(posedge ref_clk) cs_n <= 1'b0;
    #3;
    for (int p = 0; p <= pulses; p++) begin
      link_clk = 1'b1;
      #2 take(ddr ? 2*p : p, nl, ilv, w, p == pulses);
      if (p == 1) ret_hi = ret_clk;
      #1 link_clk = 1'b0;
      #2 if (ddr) take(2*p+1, nl, ilv, w, p == pulses);
      if (p == 1) ret_lo = ret_clk;
      #1;
    end
    @(posedge ref_clk) cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### adc_multilane_output_serializer_tb_top.sv
// self-checking bench of the multilane output serializer
// assumes aos_host_model as the far side; conversion words come from the bench
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("BAD %s exp %h got %h", nm, e, g); end end

module adc_multilane_output_serializer_tb_top;
  import aos_pkg::*;
  logic               ref_clk;
  logic               rst_n;
  logic               conversion_start;
  logic               cs_n;
  logic               link_clk;
  aos_cfg_t           cfg;
  logic               avg_enable;
  logic [4:0]         avg_log2;
  aos_words_t         core_words;
  logic               busy;
  wire logic [7:0]    lanes;
  int                 miscompares = 0;
  int                 n_checks = 0;

  aos_serializer dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .conversion_start(conversion_start), .cs_n(cs_n),
    .link_clk(link_clk), .cfg(cfg), .avg_enable(avg_enable), .avg_log2(avg_log2),
    .core_words(core_words), .busy_or_returned_clock(busy),
    .serial_out_lane_0(lanes[0]), .serial_out_lane_1(lanes[1]), .serial_out_lane_2(lanes[2]),
    .serial_out_lane_3(lanes[3]), .serial_out_lane_4(lanes[4]), .serial_out_lane_5(lanes[5]),
    .serial_out_lane_6(lanes[6]), .serial_out_lane_7(lanes[7])
  );
  aos_host_model host (
    .ref_clk(ref_clk), .lanes(lanes), .ret_clk(busy),
    .conversion_start(conversion_start), .cs_n(cs_n), .link_clk(link_clk)
  );

  // 250 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // configuration only changes between frames
  task automatic setup(logic [1:0] lay, logic [1:0] src, logic ddr, logic w32);
    @(posedge ref_clk);
    cfg <= '{lay, src, ddr, w32};
  endtask

  // one conversion, one read after the 300 ns wait, both words compared
  task automatic frame(logic [1:0] lay, logic [1:0] src, logic ddr, logic w32, logic [63:0] v);
    int w;
    int nl;
    int pl;
    bit dd;
    w  = w32 ? 32 : 24;
    nl = (lay == 2'h2) ? 4 : (lay == 2'h1) ? 2 : 1;
    dd = ddr && (src != 2'h0);
    pl = (lay == 2'h3) ? 2*w : w/nl;
    if (dd) pl = pl/2;
    setup(lay, src, ddr, w32);
    core_words <= v;
    host.start_conv();
    repeat (76) @(posedge ref_clk);
    host.read(nl, lay == 2'h3, dd, w, pl);
    `CHK("ch0", w32 ? v[31:0] : {8'h00, v[23:0]}, host.got0)
    `CHK("ch1", w32 ? v[63:32] : {8'h00, v[55:32]}, host.got1)
    `CHK("tail", 1'b1, host.tail_zero)
    if (src != 2'h0) `CHK("ret_hi", 1'b1, host.ret_hi)
    if (src != 2'h0) `CHK("ret_lo", 1'b0, host.ret_lo)
    repeat (5) @(posedge ref_clk);
  endtask

  // every layout, source and rate; word length set by the parity of l, s and d
  task automatic t_modes();
    for (int l = 0; l < 4; l++)
      for (int s = 0; s < 3; s++)
        for (int d = 0; d < 2; d++)
          frame(l[1:0], s[1:0], d[0], l[0] ^ s[0] ^ d[0], 64'h9e3779b97f4a7c15 + 64'(l*97 + s*13 + d));
    $display("modes done");
  endtask

  // busy window 264..300 ns; echo source shows no busy
  task automatic t_busy();
    bit fell;
    setup(2'h0, 2'h0, 1'b0, 1'b1);
    host.start_conv();
    repeat (63) @(posedge ref_clk);
    `CHK("busy_264", 1'b1, busy)
    fell = 0;
    for (int n = 66; n < 75 && !fell; n++) begin
      @(posedge ref_clk);
      fell = (busy === 1'b0);
    end
    `CHK("busy_300", 1'b1, fell)
    setup(2'h0, 2'h1, 1'b0, 1'b1);
    host.start_conv();
    repeat (37) @(posedge ref_clk);
    `CHK("no_busy", 1'b0, busy)
    repeat (45) @(posedge ref_clk);
    $display("busy done");
  endtask

  // read in zone 2 while the next conversion runs, then the newer result
  task automatic t_zone2();
    setup(2'h3, 2'h0, 1'b0, 1'b1);
    core_words <= 64'hfeedc0de_13572468;
    host.start_conv();
    repeat (76) @(posedge ref_clk);
    core_words <= 64'h2468ace0_0bad1dea;
    host.start_conv();
    host.read(1, 1'b1, 1'b0, 32, 64);
    `CHK("z2_ch0", 32'h13572468, host.got0)
    `CHK("z2_ch1", 32'hfeedc0de, host.got1)
    repeat (80) @(posedge ref_clk);
    host.read(1, 1'b1, 1'b0, 32, 64);
    `CHK("z1_ch0", 32'h0bad1dea, host.got0)
    `CHK("z1_ch1", 32'h2468ace0, host.got1)
    $display("zone2 done");
  endtask

  // block of four averaged samples: busy spans all, result at the end
  task automatic t_avg();
    setup(2'h0, 2'h0, 1'b0, 1'b1);
    avg_log2   <= 5'h02;
    avg_enable <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      core_words <= 64'h0123456789abcdef + 64'(k);
      host.start_conv();
      repeat (120) @(posedge ref_clk);
      if (k < 3) `CHK("avg_busy", 1'b1, busy)
    end
    `CHK("avg_done", 1'b0, busy)
    host.read(1, 1'b0, 1'b0, 32, 32);
    `CHK("avg_ch0", 32'h89abcdf2, host.got0)
    `CHK("avg_ch1", 32'h01234567, host.got1)
    avg_enable <= 1'b0;
    $display("avg done");
  endtask

  // reset for three cycles, then the scenarios
  initial begin
    rst_n      = 1'b0;
    cfg        = '0;
    avg_enable = 1'b0;
    avg_log2   = '0;
    core_words = '0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    t_busy();
    t_modes();
    t_zone2();
    t_avg();
    end_sim();
  end
endmodule
`default_nettype wire
